// ### rtl/msb_config_bank.sv
// Start-up and protection configuration bank with its decode logic
// How it works
// - Stationary when no zero cross within 80 to 640 ms, doubling per code.
// - Advance angle after position sensing is 30, 60, 90 or 120 degrees.
// - Initial speed detection runs only while its enable bit is one.
// - Reverse drive of a backward spinning motor only when enabled.
// - Reverse drive or braking starts at or below 6.3, 13, 26 or 51 Hz.
// - Open-loop current is 0.2, 0.4, 0.8 or 1.6 A.
// - Open-loop current ramp from 6 down to 0.023 supply volts per second.
// - Brake code zero disables braking; others pick 2.7 s down to 0.04 s.
// - Second-order start acceleration from 57 down to 0.22 Hz/s squared.
// - First-order start acceleration from 76 down to 0.3 Hz/s.
// - Handover high range is n plus one times 12.8 Hz.
// - No-motor fault reported only while its enable bit is high.
// - Abnormal back-EMF constant locks only while its enable is high.
// - Abnormal speed locks only while its enable bit is high.
// - Lock current limit locks only while its enable bit is high.
// - Inductive surge guard acts only when its enable bit is high.
// - Mechanical surge guard acts only when its enable bit is high.
// - Release after sensing brakes at zero, floats outputs at one.
`timescale 1ns/10ps
`default_nettype none

module msb_config_bank
    import msb_pkg::*;
#(
    parameter int CYC_PER_MS = CLK_FREQ_HZ / MS_PER_S
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Motor-side status from the drive core
    input wire logic isd_phase_i,
    input wire logic zero_cross_i,
    input wire logic reverse_spin_i,
    input wire logic [9:0] motor_freq_dhz_i,
    input wire logic open_loop_i,
    input wire logic [11:0] open_loop_freq_dhz_i,
    input wire logic no_motor_evt_i,
    input wire logic kt_abnormal_evt_i,
    input wire logic speed_abnormal_evt_i,
    input wire logic lock_ilimit_evt_i,
    input wire logic sense_release_i,
    // Initial speed detection
    output logic initial_speed_detect_o,
    output logic motor_stationary_o,
    output logic [9:0] stationary_window_ms_o,
    // Start-up settings
    output logic [6:0] post_sense_advance_deg_o,
    output logic [9:0] reverse_drive_threshold_dhz_o,
    output logic reverse_drive_go_o,
    output logic brake_go_o,
    output logic brake_enable_o,
    output logic [11:0] brake_duration_ms_o,
    output logic [10:0] open_loop_current_ma_o,
    output logic [12:0] open_loop_current_ramp_o,
    output logic [12:0] startup_accel_second_order_o,
    output logic [12:0] startup_accel_first_order_o,
    output logic [1:0] ctrl_coef_code_o,
    output logic [2:0] align_time_code_o,
    output logic [11:0] loop_handover_dhz_o,
    output logic loop_handover_valid_o,
    output logic loop_handover_go_o,
    // Protection
    output logic no_motor_fault_o,
    output logic lock_kt_o,
    output logic lock_speed_o,
    output logic lock_ilimit_o,
    output logic lock_any_o,
    output logic inductive_surge_guard_o,
    output logic mechanical_surge_guard_o,
    output logic surge_clamp_24v_o,
    output logic release_brake_o,
    output logic release_hiz_o
);

    localparam int PW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
    localparam logic [PW-1:0] PRESC_LAST = PW'(CYC_PER_MS - 1);
    localparam logic [9:0] MS_MAX = 10'h3FF;

    if (CYC_PER_MS < 1) begin : g_bad_presc
        $error("CYC_PER_MS must be at least one");
    end

    ////////////////////////////////////////////////////////////////////
    // Handover frequency decode
    function automatic logic [11:0] handover_dhz(input logic [4:0] c);
        logic [11:0] n;
        n = {8'h00, c[3:0]};
        if (c[4]) begin
            handover_dhz = 12'((n + 12'h001) * HO_R1_STEP_DHZ);
        end else begin
            handover_dhz = 12'(n * HO_R0_STEP_DHZ);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] start_detect_options_q;
    logic [7:0] open_loop_drive_options_q;
    logic [7:0] startup_accel_options_q;
    logic [7:0] handover_align_options_q;
    logic [7:0] fault_enable_options_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            start_detect_options_q <= RST_START;
            open_loop_drive_options_q <= RST_DRIVE;
            startup_accel_options_q <= RST_ACCEL;
            handover_align_options_q <= RST_HANDOVER;
            fault_enable_options_q <= RST_FAULT;
        end else if (reg_wr_i) begin
            // Writes to other addresses are dropped silently
            if (reg_addr_i == ADR_START) begin
                start_detect_options_q <= reg_wdata_i;
            end else if (reg_addr_i == ADR_DRIVE) begin
                open_loop_drive_options_q <= reg_wdata_i;
            end else if (reg_addr_i == ADR_ACCEL) begin
                startup_accel_options_q <= reg_wdata_i;
            end else if (reg_addr_i == ADR_HANDOVER) begin
                handover_align_options_q <= reg_wdata_i;
            end else if (reg_addr_i == ADR_FAULT) begin
                fault_enable_options_q <= reg_wdata_i;
            end
        end
    end

    logic [7:0] rdata_q;
    logic rvalid_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= RD_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_i;
            if (reg_rd_i) begin
                if (reg_addr_i == ADR_START) begin
                    rdata_q <= start_detect_options_q;
                end else if (reg_addr_i == ADR_DRIVE) begin
                    rdata_q <= open_loop_drive_options_q;
                end else if (reg_addr_i == ADR_ACCEL) begin
                    rdata_q <= startup_accel_options_q;
                end else if (reg_addr_i == ADR_HANDOVER) begin
                    rdata_q <= handover_align_options_q;
                end else if (reg_addr_i == ADR_FAULT) begin
                    rdata_q <= fault_enable_options_q;
                end else begin
                    rdata_q <= RD_UNMAPPED;
                end
            end
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    ////////////////////////////////////////////////////////////////////
    // Field views
    logic [1:0] stj_code;
    logic isd_en;
    logic rev_en;
    logic [2:0] brk_code;
    logic [4:0] ho_code;
    logic isd_active;

    assign stj_code = start_detect_options_q[STJ_HI:STJ_LO];
    assign isd_en = start_detect_options_q[ISD_EN_BIT];
    assign rev_en = start_detect_options_q[REV_EN_BIT];
    assign brk_code = open_loop_drive_options_q[BRK_HI:BRK_LO];
    assign ho_code = handover_align_options_q[HO_HI:HO_LO];
    assign isd_active = isd_phase_i & isd_en;

    ////////////////////////////////////////////////////////////////////
    // Stationary judgement timer
    // A millisecond prescaler keeps the window counter narrow; the
    // window is thus resolved to one millisecond, well inside 80 ms.
    logic [PW-1:0] presc_q;
    logic [9:0] quiet_ms_q;
    logic [9:0] window_ms;

    assign window_ms = STAT_WIN_BASE_MS[9:0] << stj_code;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !isd_active || zero_cross_i) begin
            presc_q <= '0;
            quiet_ms_q <= '0;
        end else if (presc_q == PRESC_LAST) begin
            presc_q <= '0;
            if (quiet_ms_q != MS_MAX) begin
                quiet_ms_q <= quiet_ms_q + 10'h001;
            end
        end else begin
            presc_q <= presc_q + PW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            motor_stationary_o <= 1'b0;
            initial_speed_detect_o <= 1'b0;
            stationary_window_ms_o <= '0;
        end else begin
            initial_speed_detect_o <= isd_active;
            stationary_window_ms_o <= window_ms;
            // no zero cross for the whole window
            motor_stationary_o <= isd_active && !zero_cross_i &&
                                  (quiet_ms_q >= window_ms);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Start-up settings decode
    logic [9:0] rev_thr;
    logic rev_slow;

    assign rev_thr =
        REV_THR_DHZ[start_detect_options_q[REV_THR_HI:REV_THR_LO]];
    assign rev_slow = reverse_spin_i && (motor_freq_dhz_i <= rev_thr);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            post_sense_advance_deg_o <= '0;
            reverse_drive_threshold_dhz_o <= '0;
            reverse_drive_go_o <= 1'b0;
            brake_go_o <= 1'b0;
            brake_enable_o <= 1'b0;
            brake_duration_ms_o <= '0;
            open_loop_current_ma_o <= '0;
            open_loop_current_ramp_o <= '0;
            startup_accel_second_order_o <= '0;
            startup_accel_first_order_o <= '0;
            ctrl_coef_code_o <= '0;
            align_time_code_o <= '0;
        end else begin
            post_sense_advance_deg_o <= 7'(ADV_STEP_DEG *
                ({5'h00, start_detect_options_q[ADV_HI:ADV_LO]} + 7'h01));
            reverse_drive_threshold_dhz_o <= rev_thr;
            reverse_drive_go_o <= rev_slow && rev_en;
            // braking when reverse drive is off
            brake_go_o <= rev_slow && !rev_en && (brk_code != 3'h0);
            brake_enable_o <= (brk_code != 3'h0);
            brake_duration_ms_o <= BRAKE_MS[brk_code];
            open_loop_current_ma_o <= OLC_BASE_MA <<
                open_loop_drive_options_q[OLC_HI:OLC_LO];
            open_loop_current_ramp_o <=
                RAMP_MVCC_S[open_loop_drive_options_q[RAMP_HI:RAMP_LO]];
            startup_accel_second_order_o <=
                ACC2_CHZ_S2[startup_accel_options_q[ACC2_HI:ACC2_LO]];
            startup_accel_first_order_o <=
                ACC1_CHZ_S[startup_accel_options_q[ACC1_HI:ACC1_LO]];
            ctrl_coef_code_o <= startup_accel_options_q[COEF_HI:COEF_LO];
            align_time_code_o <=
                handover_align_options_q[ALIGN_HI:ALIGN_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Open to closed loop handover
    logic [11:0] ho_dhz;
    logic ho_valid;

    assign ho_dhz = handover_dhz(ho_code);
    assign ho_valid = (ho_code != 5'h00);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            loop_handover_dhz_o <= '0;
            loop_handover_valid_o <= 1'b0;
            loop_handover_go_o <= 1'b0;
        end else begin
            loop_handover_dhz_o <= ho_dhz;
            loop_handover_valid_o <= ho_valid;
            loop_handover_go_o <= open_loop_i && ho_valid &&
                                  (open_loop_freq_dhz_i >= ho_dhz);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault and lock gating
    // Disabled events are discarded, not held: enabling a detector
    // later does not raise a stale fault.
    logic nm_f;
    logic kt_f;
    logic spd_f;
    logic il_f;

    assign nm_f = no_motor_evt_i & fault_enable_options_q[NOMOTOR_BIT];
    assign kt_f = kt_abnormal_evt_i & fault_enable_options_q[LOCK_KT_BIT];
    assign spd_f = speed_abnormal_evt_i &
                   fault_enable_options_q[LOCK_SPD_BIT];
    assign il_f = lock_ilimit_evt_i & fault_enable_options_q[LOCK_ILIM_BIT];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            no_motor_fault_o <= 1'b0;
            lock_kt_o <= 1'b0;
            lock_speed_o <= 1'b0;
            lock_ilimit_o <= 1'b0;
            lock_any_o <= 1'b0;
        end else begin
            no_motor_fault_o <= nm_f;
            lock_kt_o <= kt_f;
            lock_speed_o <= spd_f;
            lock_ilimit_o <= il_f;
            lock_any_o <= nm_f | kt_f | spd_f | il_f;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Surge guard and release mode
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            inductive_surge_guard_o <= 1'b0;
            mechanical_surge_guard_o <= 1'b0;
            surge_clamp_24v_o <= 1'b0;
            release_brake_o <= 1'b0;
            release_hiz_o <= 1'b0;
        end else begin
            inductive_surge_guard_o <= fault_enable_options_q[AVS_IND_BIT];
            mechanical_surge_guard_o <=
                fault_enable_options_q[AVS_MECH_BIT];
            // clamp level only while guard is on
            surge_clamp_24v_o <= fault_enable_options_q[AVS_MECH_BIT] &
                                 fault_enable_options_q[AVS_MODE_BIT];
            release_brake_o <= sense_release_i &
                               !fault_enable_options_q[REL_MODE_BIT];
            release_hiz_o <= sense_release_i &
                             fault_enable_options_q[REL_MODE_BIT];
        end
    end

endmodule

`default_nettype wire

// ### rtl/msb_pkg.sv
// Constants shared by the motor start-up configuration bank
package msb_pkg;

    // Clock and time base
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int STAT_WIN_BASE_MS = 80;

    // Register byte addresses
    localparam logic [7:0] ADR_START = 8'h23;
    localparam logic [7:0] ADR_DRIVE = 8'h24;
    localparam logic [7:0] ADR_ACCEL = 8'h25;
    localparam logic [7:0] ADR_HANDOVER = 8'h26;
    localparam logic [7:0] ADR_FAULT = 8'h27;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Reset values
    localparam logic [7:0] RST_START = 8'h00;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] RST_ACCEL = 8'h00;
    localparam logic [7:0] RST_HANDOVER = 8'h00;
    localparam logic [7:0] RST_FAULT = 8'h00;

    // Field positions, start_detect_options
    localparam int STJ_HI = 7, STJ_LO = 6;
    localparam int ADV_HI = 5, ADV_LO = 4;
    localparam int ISD_EN_BIT = 3;
    localparam int REV_EN_BIT = 2;
    localparam int REV_THR_HI = 1, REV_THR_LO = 0;
    // open_loop_drive_options
    localparam int OLC_HI = 7, OLC_LO = 6;
    localparam int RAMP_HI = 5, RAMP_LO = 3;
    localparam int BRK_HI = 2, BRK_LO = 0;
    // startup_accel_options
    localparam int COEF_HI = 7, COEF_LO = 6;
    localparam int ACC2_HI = 5, ACC2_LO = 3;
    localparam int ACC1_HI = 2, ACC1_LO = 0;
    // handover_align_options
    localparam int HO_HI = 7, HO_LO = 3;
    localparam int ALIGN_HI = 2, ALIGN_LO = 0;
    // fault_enable_options
    localparam int NOMOTOR_BIT = 7;
    localparam int LOCK_KT_BIT = 6;
    localparam int LOCK_SPD_BIT = 5;
    localparam int LOCK_ILIM_BIT = 4;
    localparam int AVS_IND_BIT = 3;
    localparam int AVS_MECH_BIT = 2;
    localparam int AVS_MODE_BIT = 1;
    localparam int REL_MODE_BIT = 0;

    // Decoded settings, units given in the names
    localparam logic [6:0] ADV_STEP_DEG = 7'h1E;
    localparam logic [10:0] OLC_BASE_MA = 11'h0C8;
    localparam logic [11:0] HO_R0_STEP_DHZ = 12'h008;
    localparam logic [11:0] HO_R1_STEP_DHZ = 12'h080;
    localparam logic [9:0] REV_THR_DHZ [4] = '{
        10'h03F, 10'h082, 10'h104, 10'h1FE};
    localparam logic [12:0] RAMP_MVCC_S [8] = '{
        13'h1770, 13'h0BB8, 13'h05DC, 13'h02BC,
        13'h0154, 13'h00A0, 13'h0046, 13'h0017};
    localparam logic [11:0] BRAKE_MS [8] = '{
        12'h000, 12'hA8C, 12'h514, 12'h29E,
        12'h14A, 12'h0A0, 12'h050, 12'h028};
    localparam logic [12:0] ACC2_CHZ_S2 [8] = '{
        13'h1644, 13'h0B54, 13'h0578, 13'h02B2,
        13'h014A, 13'h00A0, 13'h0042, 13'h0016};
    localparam logic [12:0] ACC1_CHZ_S [8] = '{
        13'h1DB0, 13'h0ED8, 13'h076C, 13'h0398,
        13'h01C2, 13'h00D2, 13'h005A, 13'h001E};

endpackage

// ### sim/msb_config_bank_properties.sv
// Port-level checker for the start-up configuration bank
`timescale 1ns/10ps
`default_nettype none

module msb_config_bank_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic isd_phase_i,
    input wire logic zero_cross_i,
    input wire logic reverse_spin_i,
    input wire logic [9:0] motor_freq_dhz_i,
    input wire logic open_loop_i,
    input wire logic [11:0] open_loop_freq_dhz_i,
    input wire logic no_motor_evt_i,
    input wire logic kt_abnormal_evt_i,
    input wire logic sense_release_i,
    input wire logic initial_speed_detect_o,
    input wire logic motor_stationary_o,
    input wire logic [6:0] post_sense_advance_deg_o,
    input wire logic [9:0] reverse_drive_threshold_dhz_o,
    input wire logic reverse_drive_go_o,
    input wire logic brake_go_o,
    input wire logic brake_enable_o,
    input wire logic [11:0] loop_handover_dhz_o,
    input wire logic loop_handover_valid_o,
    input wire logic loop_handover_go_o,
    input wire logic no_motor_fault_o,
    input wire logic lock_kt_o,
    input wire logic mechanical_surge_guard_o,
    input wire logic surge_clamp_24v_o,
    input wire logic release_brake_o,
    input wire logic release_hiz_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////////////////////////////////////
    chk_read_valid: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid not one cycle after read");
    chk_unmapped_zero: assert property (reg_rd_i &&
        !(reg_addr_i inside {[8'h23:8'h27]}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_isd_gated:
        assert property ($rose(initial_speed_detect_o) |-> $past(isd_phase_i))
        else $error("speed detect raised without phase");
    chk_stationary_quiet:
        assert property (motor_stationary_o |->
            $past(isd_phase_i) && !$past(zero_cross_i))
        else $error("stationary despite zero cross or phase end");
    chk_advance_set:
        assert property (post_sense_advance_deg_o != 7'h00 |->
            post_sense_advance_deg_o inside {7'h1E, 7'h3C, 7'h5A, 7'h78})
        else $error("advance angle off the table");
    chk_reverse_go:
        assert property (reverse_drive_go_o |-> $past(reverse_spin_i) &&
            $past(motor_freq_dhz_i) <= reverse_drive_threshold_dhz_o)
        else $error("reverse drive without spin below threshold");
    chk_brake_go:
        assert property (brake_go_o |-> brake_enable_o &&
            !reverse_drive_go_o && $past(reverse_spin_i))
        else $error("brake started while disabled");
    chk_fault_gated:
        assert property (no_motor_fault_o |-> $past(no_motor_evt_i))
        else $error("no-motor fault without event");
    chk_kt_gated:
        assert property (lock_kt_o |-> $past(kt_abnormal_evt_i))
        else $error("back-EMF lock without event");
    chk_clamp_mode:
        assert property (surge_clamp_24v_o |-> mechanical_surge_guard_o)
        else $error("24 V clamp without mechanical guard");
    chk_release_mode:
        assert property (release_brake_o |->
            !release_hiz_o && $past(sense_release_i))
        else $error("release brake and float together");
    chk_handover_go:
        assert property (loop_handover_go_o |-> loop_handover_valid_o &&
            $past(open_loop_i) &&
            $past(open_loop_freq_dhz_i) >= loop_handover_dhz_o)
        else $error("handover below threshold");
endmodule

bind msb_config_bank msb_config_bank_properties i_props (.*);
`default_nettype wire

// ### sim/msb_motor_model.sv
// Behavioural back-EMF source giving zero-cross pulses while spinning
`timescale 1ns/10ps
`default_nettype none

module msb_motor_model #(
    parameter int PERIOD = 100
) (
    input wire logic clk_i,
    input wire logic spinning_i,
    output logic zero_cross_o
);
    int cnt_q = 0;

    always_ff @(posedge clk_i) begin
        cnt_q <= (spinning_i && cnt_q < PERIOD - 1) ? cnt_q + 1 : 0;
        zero_cross_o <= spinning_i && cnt_q == PERIOD - 1;
    end
endmodule
`default_nettype wire

// ### sim/test_motor_startup_config_bank.sv
// Self-checking bench for the start-up configuration bank
`timescale 1ns/10ps
`default_nettype none

module test_motor_startup_config_bank;
    import msb_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, spinning = 0;
    logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o;
    logic isd_phase_i = 0, zero_cross_i, reverse_spin_i = 0, open_loop_i = 0;
    logic [9:0] motor_freq_dhz_i = '0, stationary_window_ms_o;
    logic [11:0] open_loop_freq_dhz_i = '0, loop_handover_dhz_o;
    logic no_motor_evt_i = 0, kt_abnormal_evt_i = 0, sense_release_i = 0;
    logic speed_abnormal_evt_i = 0, lock_ilimit_evt_i = 0;
    logic reg_rvalid_o, initial_speed_detect_o, motor_stationary_o;
    logic [6:0] post_sense_advance_deg_o;
    logic [9:0] reverse_drive_threshold_dhz_o;
    logic reverse_drive_go_o, brake_go_o, brake_enable_o;
    logic [11:0] brake_duration_ms_o;
    logic [10:0] open_loop_current_ma_o;
    logic [12:0] open_loop_current_ramp_o, startup_accel_second_order_o;
    logic [12:0] startup_accel_first_order_o;
    logic [1:0] ctrl_coef_code_o;
    logic [2:0] align_time_code_o;
    logic loop_handover_valid_o, loop_handover_go_o, no_motor_fault_o;
    logic lock_kt_o, lock_speed_o, lock_ilimit_o, lock_any_o;
    logic inductive_surge_guard_o, mechanical_surge_guard_o;
    logic surge_clamp_24v_o, release_brake_o, release_hiz_o;
    logic [9:0] rev_thr [4] = '{10'h03F, 10'h082, 10'h104, 10'h1FE};
    logic [7:0] fv [7] = '{8'hF0, 8'h0F, 8'hA5, 8'h5A, 8'h06, 8'h02, 8'h00};
    int n_errors = 0, tests_run = 0, n;

    // Short millisecond tick keeps the quiet window near 320 cycles
    msb_config_bank #(.CYC_PER_MS(4)) i_dut (.*);
    msb_motor_model #(.PERIOD(100)) i_motor (.clk_i(clk_i),
        .spinning_i(spinning), .zero_cross_o(zero_cross_i));

    always #10 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic expire(input int cnt, input int lim);
        if (cnt >= lim) begin
            cmp(16'hDEAD, 16'h0000);
            tally_and_finish();
        end
    endtask

    // Returns two falling edges after the store, so decoded outputs settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        cmp({reg_rvalid_o, reg_rdata_o}, {1'b1, e});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        // Reset value, read-write access, unmapped neighbours
        for (int a = 8'h22; a <= 8'h28; a++) begin
            rd(a[7:0], 8'h00);
            wr(a[7:0], 8'hA5 ^ a[7:0]);
            rd(a[7:0], (a == 8'h22 || a == 8'h28) ? 8'h00 : 8'hA5 ^ a[7:0]);
        end
        // Enable bit follows code bit 0 while the phase input is high
        isd_phase_i = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(ADR_START, {c[1:0], c[1:0], c[0], 1'b0, c[1:0]});
            cmp(stationary_window_ms_o, 16'h0050 << c);
            cmp(post_sense_advance_deg_o, 16'(16'h001E * (c + 1)));
            cmp(reverse_drive_threshold_dhz_o, rev_thr[c]);
            cmp(initial_speed_detect_o, c[0]);
        end
        isd_phase_i = 1'b0;
        for (int c = 0; c < 8; c++) begin
            wr(ADR_DRIVE, {c[1:0], c[2:0], c[2:0]});
            cmp(open_loop_current_ma_o, 16'h00C8 << c[1:0]);
            cmp(open_loop_current_ramp_o, RAMP_MVCC_S[c]);
            cmp(brake_duration_ms_o, BRAKE_MS[c]);
            cmp(brake_enable_o, c != 0);
            wr(ADR_ACCEL, {c[1:0], c[2:0], c[2:0]});
            cmp(startup_accel_second_order_o, ACC2_CHZ_S2[c]);
            cmp(startup_accel_first_order_o, ACC1_CHZ_S[c]);
            cmp(ctrl_coef_code_o, c[1:0]);
        end
        for (int c = 0; c < 32; c++) begin
            wr(ADR_HANDOVER, {c[4:0], c[2:0]});
            n = (c < 16) ? c * 8 : (c - 15) * 128;
            cmp(loop_handover_dhz_o, n[15:0]);
            cmp(loop_handover_valid_o, c != 0);
            cmp(align_time_code_o, c[2:0]);
        end
        {no_motor_evt_i, kt_abnormal_evt_i, sense_release_i} = 3'h7;
        {speed_abnormal_evt_i, lock_ilimit_evt_i} = 2'h3;
        for (int i = 0; i < 7; i++) begin
            wr(ADR_FAULT, fv[i]);
            cmp({no_motor_fault_o, lock_kt_o}, fv[i][7:6]);
            cmp({lock_speed_o, lock_ilimit_o}, fv[i][5:4]);
            cmp(lock_any_o, |fv[i][7:4]);
            cmp(inductive_surge_guard_o, fv[i][3]);
            cmp(mechanical_surge_guard_o, fv[i][2]);
            cmp(surge_clamp_24v_o, fv[i][2] & fv[i][1]);
            cmp({release_brake_o, release_hiz_o},
                {~fv[i][0], fv[i][0]});
        end
        {no_motor_evt_i, kt_abnormal_evt_i, sense_release_i} = 3'h0;
        {speed_abnormal_evt_i, lock_ilimit_evt_i} = 2'h0;
        wr(ADR_FAULT, 8'hF0);
        cmp({lock_any_o, release_brake_o}, 2'b00);
        reverse_spin_i = 1'b1;
        motor_freq_dhz_i = 10'h03F;
        wr(ADR_START, 8'h04);
        cmp({reverse_drive_go_o, brake_go_o}, 2'b10);
        motor_freq_dhz_i = 10'h040;
        @(negedge clk_i);
        cmp({reverse_drive_go_o, brake_go_o}, 2'b00);
        motor_freq_dhz_i = 10'h1FE;
        wr(ADR_START, 8'h03);
        wr(ADR_DRIVE, 8'h07);
        cmp({reverse_drive_go_o, brake_go_o}, 2'b01);
        wr(ADR_DRIVE, 8'h00);
        cmp({reverse_drive_go_o, brake_go_o}, 2'b00);
        reverse_spin_i = 1'b0;
        open_loop_i = 1'b1;
        open_loop_freq_dhz_i = 12'h088;
        wr(ADR_HANDOVER, 8'h80);
        cmp(loop_handover_go_o, 1'b1);
        wr(ADR_HANDOVER, 8'h88);
        cmp(loop_handover_go_o, 1'b0);
        open_loop_i = 1'b0;
        // Spinning rotor keeps the judge quiet; stop right after a cross
        wr(ADR_START, 8'h08);
        isd_phase_i = 1'b1;
        spinning = 1'b1;
        repeat (600) @(negedge clk_i);
        cmp({initial_speed_detect_o, motor_stationary_o},
            2'b10);
        for (n = 0; n < 200 && zero_cross_i !== 1'b1; n++) @(negedge clk_i);
        expire(n, 200);
        spinning = 1'b0;
        for (n = 0; n < 400 && motor_stationary_o !== 1'b1; n++)
            @(negedge clk_i);
        expire(n, 400);
        cmp(n >= 316 && n <= 328, 1'b1);
        spinning = 1'b1;
        repeat (103) @(negedge clk_i);
        cmp(motor_stationary_o, 1'b0);
        spinning = 1'b0;
        wr(ADR_START, 8'h00);
        repeat (400) @(negedge clk_i);
        cmp({initial_speed_detect_o, motor_stationary_o},
            2'b00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
